// ---- src/pse_event_pkg.sv ----
// constants for the event status register bank
package pse_event_pkg;
   localparam int          CHANNELS        = 4;
   localparam int          CLASS_W         = 4;
   localparam int          DETECT_W        = 4;
   // command codes, peek then clearing read
   localparam logic [7:0]  CMD_DETECT_PEEK = 8'h04;
   localparam logic [7:0]  CMD_DETECT_CLR  = 8'h05;
   localparam logic [7:0]  CMD_FAULT_PEEK  = 8'h06;
   localparam logic [7:0]  CMD_FAULT_CLR   = 8'h07;
   localparam logic [7:0]  CMD_START_PEEK  = 8'h08;
   localparam logic [7:0]  CMD_START_CLR   = 8'h09;
   localparam logic [7:0]  CMD_SUPPLY_PEEK = 8'h0A;
   localparam logic [7:0]  CMD_SUPPLY_CLR  = 8'h0B;
   // reset values and the all-ones clear mask
   localparam logic [7:0]  EVENT_RESET     = 8'h00;
   localparam logic [7:0]  SUPPLY_RESET    = 8'h70;
   localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
   localparam logic [3:0]  NIBBLE_ZERO     = 4'h0;
   localparam logic [7:0]  ALL_CLEAR       = 8'hFF;
   // supply and fault event bit positions
   localparam int          SUP_THERMAL     = 7;
   localparam int          SUP_CORE_LOCK   = 6;
   localparam int          SUP_CORE_WARN   = 5;
   localparam int          SUP_PWR_UV      = 4;
   localparam int          SUP_FAST_SHDN   = 1;
   localparam int          SUP_MEMORY      = 0;
   // interrupt mask and summary bit positions
   localparam int          MSK_SUPPLY      = 7;
   localparam int          MSK_START       = 6;
   localparam int          MSK_LIMIT       = 5;
   localparam int          MSK_CLASS       = 4;
   localparam int          MSK_DETECT      = 3;
   localparam int          MSK_DISCONNECT  = 2;
endpackage : pse_event_pkg

// ---- src/pse_event_status_registers.sv ----
// sticky event status registers for a four channel power sourcing controller
module pse_event_status_registers
   import pse_event_pkg::*;
(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_reset,
   // command port of the serial interface
   input  wire logic                        i_rd_strobe,
   input  wire logic [7:0]                  i_rd_cmd,
   output logic      [7:0]                  o_rd_data,
   output logic                             o_rd_valid,
   // configuration
   input  wire logic                        i_class_change_only_enable,
   input  wire logic                        i_detect_change_only_enable,
   input  wire logic                        i_auto_mode,
   input  wire logic [7:0]                  i_int_mask,
   input  wire logic                        i_int_enable,
   input  wire logic [CHANNELS-1:0]         i_power_enable_change_flag,
   // per channel event pulses
   input  wire logic [CHANNELS-1:0]         i_class_done,
   input  wire logic [CHANNELS*CLASS_W-1:0] i_class_value,
   input  wire logic [CHANNELS-1:0]         i_detect_done,
   input  wire logic [CHANNELS*DETECT_W-1:0] i_detect_value,
   input  wire logic [CHANNELS-1:0]         i_disconnect,
   input  wire logic [CHANNELS-1:0]         i_overload_fault,
   input  wire logic [CHANNELS-1:0]         i_current_limit_fault,
   input  wire logic [CHANNELS-1:0]         i_start_time_fault,
   input  wire logic [CHANNELS-1:0]         i_discovery_error,
   input  wire logic [CHANNELS-1:0]         i_channel_off,
   // supply events
   input  wire logic                        i_thermal_shutdown,
   input  wire logic                        i_core_supply_lockout,
   input  wire logic                        i_core_supply_warning,
   input  wire logic                        i_power_supply_undervoltage,
   input  wire logic                        i_fast_shutdown_disable,
   input  wire logic                        i_memory_fault,
   // outputs
   output logic      [7:0]                  o_event_summary,
   output logic                             o_int_n,
   output logic                             o_turn_off_all,
   output logic      [CHANNELS-1:0]         o_power_on_fault_write,
   output logic      [CHANNELS-1:0]         o_power_on_fault_discovery
);

   // set wins over clear so an event in the clearing cycle survives
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic [7:0] clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   logic [7:0]                   detect_class_event;
   logic [7:0]                   disconnect_overload_event;
   logic [7:0]                   start_limit_event;
   logic [7:0]                   supply_fault_event;
   logic [CHANNELS*CLASS_W-1:0]  last_class;
   logic [CHANNELS*DETECT_W-1:0] last_detect;

   // read decode
   wire       rd_detect_clr = i_rd_strobe && (i_rd_cmd == CMD_DETECT_CLR);
   wire       rd_fault_clr  = i_rd_strobe && (i_rd_cmd == CMD_FAULT_CLR);
   wire       rd_start_clr  = i_rd_strobe && (i_rd_cmd == CMD_START_CLR);
   wire       rd_supply_clr = i_rd_strobe && (i_rd_cmd == CMD_SUPPLY_CLR);
   logic [7:0] rd_select;

   // both codes of a register return the same value
   always_comb begin
      unique case (i_rd_cmd)
         CMD_DETECT_PEEK, CMD_DETECT_CLR: rd_select = detect_class_event;
         CMD_FAULT_PEEK,  CMD_FAULT_CLR:  rd_select = disconnect_overload_event;
         CMD_START_PEEK,  CMD_START_CLR:  rd_select = start_limit_event;
         CMD_SUPPLY_PEEK, CMD_SUPPLY_CLR: rd_select = supply_fault_event;
         default:                         rd_select = UNMAPPED_DATA;
      endcase
   end

   // thermal shutdown forces every channel off, logic here keeps running
   assign o_turn_off_all = i_thermal_shutdown;
   wire [CHANNELS-1:0] off_ch = i_channel_off |
                                {CHANNELS{i_thermal_shutdown}};
   wire [7:0] off_mask = {off_ch, off_ch};

   // class and detect change qualification per channel
   logic [CHANNELS-1:0] class_set;
   logic [CHANNELS-1:0] detect_set;
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         class_set[c] = i_class_done[c] && (!i_class_change_only_enable ||
            (i_class_value[c*CLASS_W +: CLASS_W] !=
             last_class[c*CLASS_W +: CLASS_W]));
         detect_set[c] = i_detect_done[c] && (!i_detect_change_only_enable ||
            (i_detect_value[c*DETECT_W +: DETECT_W] !=
             last_detect[c*DETECT_W +: DETECT_W]));
      end
   end

   // discovery errors do not count as start faults in automatic mode
   wire [CHANNELS-1:0] disc_err   = i_discovery_error &
                                    {CHANNELS{!i_auto_mode}};
   wire [CHANNELS-1:0] start_set  = i_start_time_fault | disc_err;
   wire [CHANNELS-1:0] cause_wr   = start_set &
                                    ~i_power_enable_change_flag;

   // set vectors, channel 1 in bit 0 of each nibble
   wire [7:0] dc_set  = {class_set, detect_set};
   wire [7:0] fo_set  = {i_disconnect, i_overload_fault};
   wire [7:0] sl_set  = {i_current_limit_fault, start_set};
   logic [7:0] sup_set;
   always_comb begin
      sup_set                = EVENT_RESET;
      sup_set[SUP_THERMAL]   = i_thermal_shutdown;
      sup_set[SUP_CORE_LOCK] = i_core_supply_lockout;
      sup_set[SUP_CORE_WARN] = i_core_supply_warning;
      sup_set[SUP_PWR_UV]    = i_power_supply_undervoltage;
      sup_set[SUP_FAST_SHDN] = i_fast_shutdown_disable;
      sup_set[SUP_MEMORY]    = i_memory_fault;
   end

   // clear vectors: clearing read wipes all, turn-off wipes the channel
   wire [7:0] dc_clr  = (rd_detect_clr ? ALL_CLEAR : EVENT_RESET) | off_mask;
   wire [7:0] fo_clr  = (rd_fault_clr  ? ALL_CLEAR : EVENT_RESET) | off_mask;
   wire [7:0] sl_clr  = (rd_start_clr  ? ALL_CLEAR : EVENT_RESET) | off_mask;
   wire [7:0] sup_clr = rd_supply_clr ? ALL_CLEAR : EVENT_RESET;

   wire [7:0] next_dc  = sticky(detect_class_event, dc_set, dc_clr);
   // only the status bit is touched, limit counters live elsewhere
   wire [7:0] next_fo  = sticky(disconnect_overload_event, fo_set,
                                fo_clr);
   wire [7:0] next_sl  = sticky(start_limit_event, sl_set, sl_clr);
   wire [7:0] next_sup = sticky(supply_fault_event, sup_set, sup_clr);

   // event registers hold until cleared
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         detect_class_event        <= EVENT_RESET;
         disconnect_overload_event <= EVENT_RESET;
         start_limit_event         <= EVENT_RESET;
         supply_fault_event        <= SUPPLY_RESET;
      end else begin
         detect_class_event        <= next_dc;
         disconnect_overload_event <= next_fo;
         start_limit_event         <= next_sl;
         supply_fault_event        <= next_sup;
      end
   end

   // last class and detect results, for change-only reporting
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         last_class  <= '0;
         last_detect <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            if (i_class_done[c]) begin
               last_class[c*CLASS_W +: CLASS_W] <=
                  i_class_value[c*CLASS_W +: CLASS_W];
            end
            if (i_detect_done[c]) begin
               last_detect[c*DETECT_W +: DETECT_W] <=
                  i_detect_value[c*DETECT_W +: DETECT_W];
            end
         end
      end
   end

   // read data and power-on fault cause strobes are registered
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_rd_data                  <= UNMAPPED_DATA;
         o_rd_valid                 <= 1'b0;
         o_power_on_fault_write     <= '0;
         o_power_on_fault_discovery <= '0;
      end else begin
         o_rd_valid                 <= i_rd_strobe;
         if (i_rd_strobe) begin
            o_rd_data <= rd_select;
         end
         o_power_on_fault_write     <= cause_wr;
         o_power_on_fault_discovery <= cause_wr & disc_err;
      end
   end

   // summary follows register contents, so a clearing read drops it
   always_comb begin
      o_event_summary                 = EVENT_RESET;
      o_event_summary[MSK_SUPPLY]     = |supply_fault_event;
      o_event_summary[MSK_START]      = |start_limit_event[3:0];
      o_event_summary[MSK_LIMIT]      = |start_limit_event[7:4] |
                                        |disconnect_overload_event[3:0];
      o_event_summary[MSK_CLASS]      = |detect_class_event[7:4];
      o_event_summary[MSK_DETECT]     = |detect_class_event[3:0];
      o_event_summary[MSK_DISCONNECT] = |disconnect_overload_event[7:4];
   end

   // masked categories cannot pull the pin; pin released when emptied
   wire int_req = i_int_enable && |(o_event_summary & i_int_mask);
   assign o_int_n = !int_req;

endmodule : pse_event_status_registers

// ---- tb/pse_event_properties.sv ----
// concurrent checks on the event status register bank ports
module pse_event_properties
   import pse_event_pkg::*;
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_reset,
   input  wire logic                i_rd_strobe,
   input  wire logic                o_rd_valid,
   input  wire logic [7:0]          i_int_mask,
   input  wire logic                i_int_enable,
   input  wire logic [CHANNELS-1:0] i_disconnect,
   input  wire logic [CHANNELS-1:0] i_channel_off,
   input  wire logic [CHANNELS-1:0] i_start_time_fault,
   input  wire logic [CHANNELS-1:0] i_discovery_error,
   input  wire logic                i_thermal_shutdown,
   input  wire logic [7:0]          o_event_summary,
   input  wire logic                o_int_n,
   input  wire logic                o_turn_off_all,
   input  wire logic [CHANNELS-1:0] o_power_on_fault_write
);
   // one clock domain, so clocking and disable are shared
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   a_read_answer: assert property (i_rd_strobe |=> o_rd_valid)
      else $error("no answer one cycle after a read strobe");
   a_no_stray_valid: assert property (o_rd_valid |-> $past(i_rd_strobe))
      else $error("read answer without a strobe");
   a_turn_off_all: assert property (o_turn_off_all == i_thermal_shutdown)
      else $error("turn-off does not follow thermal shutdown");
   a_supply_summary: assert property (i_thermal_shutdown |=>
      o_event_summary[MSK_SUPPLY])
      else $error("thermal event missing from summary");
   a_disc_summary: assert property (|i_disconnect |=>
      o_event_summary[MSK_DISCONNECT])
      else $error("disconnect event missing from summary");
   a_int_level: assert property (o_int_n ==
      !(i_int_enable && |(o_event_summary & i_int_mask)))
      else $error("interrupt pin disagrees with masked summary");
   a_detect_sticky: assert property (o_event_summary[MSK_DETECT] &&
      !i_rd_strobe && !(|i_channel_off) && !i_thermal_shutdown |=>
      o_event_summary[MSK_DETECT])
      else $error("detect event dropped without a cause");
   a_fault_cause: assert property (|o_power_on_fault_write |->
      $past(|(i_start_time_fault | i_discovery_error)))
      else $error("power-on fault written without a start fault");
   // main scenarios reached
   c_read: cover property (i_rd_strobe);
   c_int: cover property (!o_int_n);
   c_fault: cover property (|o_power_on_fault_write);
endmodule : pse_event_properties

bind pse_event_status_registers pse_event_properties u_props (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_rd_strobe(i_rd_strobe),
   .o_rd_valid(o_rd_valid), .i_int_mask(i_int_mask),
   .i_int_enable(i_int_enable), .i_disconnect(i_disconnect),
   .i_channel_off(i_channel_off), .i_start_time_fault(i_start_time_fault),
   .i_discovery_error(i_discovery_error), .o_int_n(o_int_n),
   .i_thermal_shutdown(i_thermal_shutdown), .o_turn_off_all(o_turn_off_all),
   .o_event_summary(o_event_summary),
   .o_power_on_fault_write(o_power_on_fault_write));

// ---- tb/pse_host_model.sv ----
// host processor model issuing single byte reads on the command port
module pse_host_model
(
   input  wire logic       i_ref_clk,
   output logic            o_rd_strobe,
   output logic [7:0]      o_rd_cmd,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_rd_strobe = 1'b0;
      o_rd_cmd    = 8'h00;
   end
   // strobe stands for the taking edge only; the answer is looked at from
   // the edge after it, where the one-cycle valid pulse still stands
   task automatic read(input logic [7:0] cmd, output logic [7:0] data,
                       output bit ok);
      ok = 1'b0;
      data = 8'h00;
      @(posedge i_ref_clk);
      o_rd_strobe <= 1'b1;
      o_rd_cmd    <= cmd;
      @(posedge i_ref_clk);
      o_rd_strobe <= 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         ok = (i_rd_valid === 1'b1);
         data = i_rd_data;
         if (!ok) begin
            @(posedge i_ref_clk);
         end
      end
   endtask : read
endmodule : pse_host_model

// ---- tb/testbench.sv ----
// self-checking bench for the event status register bank
module testbench
   import pse_event_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, cc_en = 1'b0, dc_en = 1'b0;
   logic        auto = 1'b0, int_en = 1'b0, thermal = 1'b0, lockout = 1'b0;
   logic        warn = 1'b0, puv = 1'b0, fshdn = 1'b0, memf = 1'b0;
   logic [7:0]  mask = 8'h00;
   logic [3:0]  pec = 4'h0, cdone = 4'h0, ddone = 4'h0, disc = 4'h0;
   logic [3:0]  ovl = 4'h0, ilim = 4'h0, stf = 4'h0, derr = 4'h0, off = 4'h0;
   logic [15:0] cval = 16'h0000, dval = 16'h0000;
   logic        strobe, valid, int_n, toff;
   logic [7:0]  cmd, rdata, summ;
   logic [3:0]  pofw, pofd;
   int          n_fail = 0, checked = 0;

   pse_event_status_registers u_dut (
      .i_ref_clk(clk), .i_reset(rst), .i_rd_strobe(strobe), .i_rd_cmd(cmd),
      .o_rd_data(rdata), .o_rd_valid(valid),
      .i_class_change_only_enable(cc_en), .i_detect_change_only_enable(dc_en),
      .i_auto_mode(auto), .i_int_mask(mask), .i_int_enable(int_en),
      .i_power_enable_change_flag(pec), .i_class_done(cdone),
      .i_class_value(cval), .i_detect_done(ddone), .i_detect_value(dval),
      .i_disconnect(disc), .i_overload_fault(ovl), .i_current_limit_fault(ilim),
      .i_start_time_fault(stf), .i_discovery_error(derr), .i_channel_off(off),
      .i_thermal_shutdown(thermal), .i_core_supply_lockout(lockout),
      .i_core_supply_warning(warn), .i_power_supply_undervoltage(puv),
      .i_fast_shutdown_disable(fshdn), .i_memory_fault(memf),
      .o_event_summary(summ), .o_int_n(int_n), .o_turn_off_all(toff),
      .o_power_on_fault_write(pofw), .o_power_on_fault_discovery(pofd));
   pse_host_model u_host (.i_ref_clk(clk), .o_rd_strobe(strobe),
      .o_rd_cmd(cmd), .i_rd_data(rdata), .i_rd_valid(valid));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // byte and flag comparisons; four-state equality so unknowns fail
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp_bit(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask : cmp_bit

   // a lost answer ends the run rather than hanging it
   task automatic rd(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] d;
      bit         ok;
      u_host.read(c, d, ok);
      if (!ok) begin
         n_fail++;
         give_verdict();
      end
      else cmp8(d, exp);
   endtask : rd

   // one cycle event pulse on the chosen per-channel input
   task automatic pulse(input int k, input logic [3:0] v);
      @(posedge clk);
      case (k)
         0: cdone <= v;
         1: ddone <= v;
         2: disc <= v;
         3: ovl <= v;
         4: ilim <= v;
         5: stf <= v;
         6: derr <= v;
         default: off <= v;
      endcase
      @(posedge clk);
      {cdone, ddone, disc, ovl, ilim, stf, derr, off} <= '0;
   endtask : pulse

   initial begin
      logic [7:0] e, c;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // every code after reset, ending on one unmapped code
      for (int i = 4; i < 13; i++) begin
         rd(8'(i), (i inside {10, 11}) ? SUPPLY_RESET : EVENT_RESET);
      end
      $display("test reset values done");
      // each per-channel event but discovery error in its nibble; peek keeps it, the odd code empties it
      for (int k = 0; k < 6; k++) begin
         pulse(k, 4'(4'h1 << (k % 4)));
         e = ((k % 2) != 0 ? 8'h01 : 8'h10) << (k % 4);
         c = 8'(4 + 2 * (k / 2));
         rd(c, e);
         rd(c, e);
         rd(c + 8'h01, e);
         rd(c, 8'h00);
      end
      $display("test event layout done");
      // change-only mode refuses a repeated value and takes a new one
      cc_en <= 1'b1;
      dc_en <= 1'b1;
      pulse(0, 4'h1);
      pulse(1, 4'h1);
      rd(8'h04, 8'h00);
      cval <= 16'h0005;
      dval <= 16'h0002;
      pulse(0, 4'h1);
      pulse(1, 4'h1);
      rd(8'h05, 8'h11);
      $display("test change-only done");
      // turning channel 2 off leaves channel 1 untouched
      pulse(2, 4'h2);
      pulse(3, 4'h3);
      pulse(7, 4'h2);
      rd(8'h07, 8'h01);
      $display("test turn-off done");
      // discovery errors count only outside automatic mode
      auto <= 1'b1;
      pulse(6, 4'h1);
      #1 cmp8({pofw, pofd}, 8'h00);
      rd(8'h09, 8'h00);
      auto <= 1'b0;
      pulse(6, 4'h1);
      #1 cmp8({pofw, pofd}, 8'h11);
      rd(8'h09, 8'h01);
      // start fault with power-enable-change set is an inrush fault
      pec <= 4'h1;
      pulse(5, 4'h1);
      #1 cmp8({pofw, pofd}, 8'h00);
      rd(8'h09, 8'h01);
      pec <= 4'h0;
      $display("test discovery errors done");
      // supply events, masking and release of the interrupt pin
      @(posedge clk);
      {thermal, lockout, warn, puv, fshdn, memf} <= '1;
      int_en <= 1'b1;
      #1 cmp_bit(toff, 1'b1);
      @(posedge clk);
      {thermal, lockout, warn, puv, fshdn, memf} <= '0;
      @(posedge clk);
      cmp_bit(int_n, 1'b1);
      mask <= 8'h80;
      @(posedge clk);
      cmp_bit(int_n, 1'b0);
      cmp8(summ, 8'h80);
      rd(8'h0A, 8'hF3);
      rd(8'h0B, 8'hF3);
      cmp_bit(int_n, 1'b1);
      $display("test supply events done");
      give_verdict();
   end
endmodule : testbench
